/* core/mrs_pkg.sv */
// shared constants and types for the memory request and strobe front end
package mrs_pkg;

  // system clock
  localparam int CLK_NS = 4;

  // row-to-column delays, least times, rounded up to whole cycles
  localparam int COL_SEL_NS = 45;
  localparam int COL_STB_NS = 75;
  localparam logic [4:0] COL_SEL_CYC = 5'((COL_SEL_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] COL_STB_CYC = 5'((COL_STB_NS + CLK_NS - 1) / CLK_NS);

  // bus clock loss detection and slow oscillator
  localparam logic [6:0] BUS_TIMEOUT_CYC = 7'h40;
  localparam logic [3:0] SLOW_HALF = 4'h8;
  localparam logic [5:0] INH_CYC = 6'h20;

  // bus word fields
  localparam int DATA_CMD_MSB = 31;
  localparam int DATA_CMD_LSB = 25;
  localparam int DATA_ADDR_MSB = 23;
  localparam int DATA_ADDR_LSB = 17;

  // command latch fields: mask <31:28>, function <27:25>
  localparam int CMD_MASK_MSB = 6;
  localparam int CMD_MASK_LSB = 3;
  localparam int CMD_FUNC_MSB = 2;
  localparam int FUNC_WR_BIT = 1;
  localparam int FUNC_NOCYC_BIT = 2;

  // register map, byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_BASE = 8'h08;

  // config fields and reset values
  localparam int CFG_SIZE_LSB = 0;
  localparam int CFG_SIZE_MSB = 3;
  localparam int CFG_ILL_BIT = 4;
  localparam logic [3:0] CFG_SIZE_RST = 4'h0;
  localparam logic CFG_ILL_RST = 1'b0;

  // status fields
  localparam int ST_BUSY_NOW = 0;
  localparam int ST_BUSY_PREV = 1;
  localparam int ST_REQ_LATCHED = 2;
  localparam int ST_REQ_NEXT = 3;
  localparam int ST_QUEUED = 4;
  localparam int ST_FAST = 5;
  localparam int ST_EXISTS = 6;
  localparam int ST_ALL_BYTES = 7;
  localparam int ST_LANES_LSB = 8;
  localparam int ST_FUNC_LSB = 12;
  localparam int ST_NOCYC = 15;
  localparam int ST_BOARD_LSB = 16;

  // ahb
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic {MODE_SLOW, MODE_FAST} mrs_mode_e;

endpackage

/* core/mrs_strobe_ctrl.sv */
// request detection, board select, command latch and row/column strobes
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
// Operation
// - mem_exists only when latched address, size, legal config and base agree.
// - buffer jumper base address; drive it on internal bus while enabled.
// - eight board selects latched on addr_reg_latch; one only if valid.
// - request only when addressed and busy newly asserted this bus cycle.
// - drive busy after qualifying; not in fast write without queued request.
// - busy_now sampled per bus clock; delayed stage forms busy_prev.
// - latch request when busy_now, not busy_prev, exists, legit, not queued.
// - slow mode moves request through phase_b then phase_a stages.
// - queue flag when request pending, cycle running, fast mode.
// - strobes begin on fast request, queued request, slow request or refresh.
// - idle_row_start when idle, requested, no refresh, legit, exists, fast.
// - register row start on bus clock or phase_a; extend row_strobe as sequenced.
// - column select then column strobe at fixed delays after row.
// - queued_row_start when queued, cycle 0 next, no refresh, no inhibit.
// - slow_row_start when cycle 0 next, no inhibit, request, no refresh.
// - refresh row start in cycle 0 or 1; column strobe gated by inhibit.
// - new transaction pulses cmd_latch_en and captures command bits.
// - command splits into all-bytes, four-bit mask and function code.
// - addr_reg_latch copies mask and all-bytes into hold register.
// - ecc_error keeps busy driven one extra bus cycle.
// - capture upper address bits on cmd_latch_en.
// - function code decodes to read/write operand and no_cycle_code.
module mrs_strobe_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // shared memory bus pins
  input wire logic bus_clock_line,
  input wire logic bus_busy_line_n_i,
  output logic bus_busy_line_n_o,
  output logic bus_busy_line_oe,
  input wire logic [31:0] bus_data_in,
  // backplane jumpers
  input wire logic [6:0] jumper_base_addr_n,
  // from the cycle sequencer
  input wire logic addr_reg_latch,
  input wire logic base_to_databus_en,
  input wire logic seq_idle,
  input wire logic cycle0_next,
  input wire logic seq_in_cycle01,
  input wire logic cycle_in_progress,
  input wire logic refresh_req,
  input wire logic refresh_pending,
  input wire logic refresh_next,
  input wire logic row_strobe_extend,
  input wire logic col_inhibit,
  input wire logic ecc_error,
  // decode and select outputs
  output logic mem_exists,
  output logic [7:0] board_select,
  output logic [6:0] base_databus,
  output logic base_databus_oe,
  output logic cmd_latch_en,
  output logic [3:0] byte_lanes,
  output logic all_bytes,
  output logic rd_wr_op,
  output logic no_cycle_code,
  // request state
  output logic busy_now,
  output logic busy_prev,
  output logic mem_req_latched,
  output logic mem_req_pending_next,
  output logic mem_req_queued,
  output logic fast_mode,
  output logic req_inhibit,
  output logic phase_a_clk,
  output logic phase_b_clk,
  // array strobes
  output logic row_strobe,
  output logic col_addr_select,
  output logic col_strobe,
  output logic refresh_row_start
);
  import mrs_pkg::*;

  function automatic logic [7:0] board_decode(input logic [6:0] addr,
      input logic [6:0] base, input logic [3:0] size, input logic ill);
    logic [6:0] offs;
    offs = 7'(addr - base);
    board_decode = 8'h00;
    if (!ill && addr >= base && offs < {3'h0, size}) begin
      board_decode = 8'(8'h01 << offs[2:0]);
    end
  endfunction

  logic clk_s1, clk_s2, clk_d;
  logic busy_s1, busy_s2, busy_del;
  logic [13:0] data_s1, data_s2;
  logic [6:0] jmp_s1, jmp_s2;
  logic [6:0] base_q, addr_q, cmd_q;
  logic [3:0] cfg_size;
  logic cfg_ill;
  mrs_mode_e mode;
  logic [6:0] wd_cnt;
  logic [5:0] inh_cnt;
  logic [3:0] div_cnt;
  logic slow_stage, row_start_reg, ecc_ext;
  logic [4:0] rs_cnt;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic bus_rise, bus_fall, busy_seen, new_txn, mem_req, legit;
  logic idle_row_start, queued_row_start, slow_row_start;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_d <= 1'b0;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      data_s1 <= 14'h0;
      data_s2 <= 14'h0;
      jmp_s1 <= 7'h7f;
      jmp_s2 <= 7'h7f;
    end else begin
      clk_s1 <= bus_clock_line;
      clk_s2 <= clk_s1;
      clk_d <= clk_s2;
      busy_s1 <= ~bus_busy_line_n_i;
      busy_s2 <= busy_s1;
      data_s1 <= {bus_data_in[DATA_CMD_MSB:DATA_CMD_LSB],
                  bus_data_in[DATA_ADDR_MSB:DATA_ADDR_LSB]};
      data_s2 <= data_s1;
      jmp_s1 <= jumper_base_addr_n;
      jmp_s2 <= jmp_s1;
    end
  end

  // edges seen after the synchroniser; the second copy feeds the delay flop
  assign bus_rise = clk_s2 & ~clk_d;
  assign bus_fall = ~clk_s2 & clk_d;
  // our own busy drive must not look like a new transaction
  assign busy_seen = busy_s2 & ~bus_busy_line_oe;

  ////////////////////////////////////////////////////////////////////////////
  // clock mode: fast while bus clock edges keep arriving

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_SLOW;
      fast_mode <= 1'b0;
      wd_cnt <= 7'h0;
      inh_cnt <= 6'h0;
    end else begin
      if (inh_cnt != 6'h0) begin
        inh_cnt <= inh_cnt - 6'h1;
      end
      case (mode)
        MODE_SLOW: begin
          if (bus_rise) begin
            mode <= MODE_FAST;
            fast_mode <= 1'b1;
            wd_cnt <= 7'h0;
            inh_cnt <= INH_CYC;
          end
        end
        MODE_FAST: begin
          if (bus_rise) begin
            wd_cnt <= 7'h0;
          end else if (wd_cnt == BUS_TIMEOUT_CYC - 7'h1) begin
            mode <= MODE_SLOW;
            fast_mode <= 1'b0;
            inh_cnt <= INH_CYC;
          end else begin
            wd_cnt <= wd_cnt + 7'h1;
          end
        end
        default: begin
          mode <= MODE_SLOW;
          fast_mode <= 1'b0;
        end
      endcase
    end
  end

  // queued and slow row starts held off while the clock source changes over
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_inhibit <= 1'b0;
    end else begin
      req_inhibit <= inh_cnt != 6'h0;
    end
  end

  // slow oscillator phases, enable pulses only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
      phase_a_clk <= 1'b0;
      phase_b_clk <= 1'b0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
      phase_a_clk <= !fast_mode && div_cnt == 4'h0;
      phase_b_clk <= !fast_mode && div_cnt == SLOW_HALF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy history and command latch

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_now <= 1'b0;
      busy_del <= 1'b0;
      busy_prev <= 1'b0;
    end else begin
      if (bus_rise) begin
        busy_now <= busy_seen;
        busy_prev <= busy_del;
      end
      if (bus_fall) begin
        busy_del <= busy_now;
      end
    end
  end

  assign new_txn = busy_now & ~busy_prev;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_latch_en <= 1'b0;
      cmd_q <= 7'h0;
      addr_q <= 7'h0;
    end else begin
      cmd_latch_en <= bus_rise && busy_seen && !busy_now;
      if (bus_rise && busy_seen && !busy_now) begin
        cmd_q <= data_s2[13:7];
        addr_q <= data_s2[6:0];
      end
    end
  end

  // mask <31:28> and function <27:25> of the captured command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_wr_op <= 1'b0;
      no_cycle_code <= 1'b1;
    end else begin
      rd_wr_op <= cmd_q[FUNC_WR_BIT];
      no_cycle_code <= cmd_q[FUNC_NOCYC_BIT];
    end
  end

  assign legit = ~no_cycle_code;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_lanes <= 4'h0;
      all_bytes <= 1'b0;
    end else if (addr_reg_latch) begin
      byte_lanes <= cmd_q[CMD_MASK_MSB:CMD_MASK_LSB];
      all_bytes <= &cmd_q[CMD_MASK_MSB:CMD_MASK_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // base address, existence and board select

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_q <= 7'h0;
      base_databus <= 7'h0;
      base_databus_oe <= 1'b0;
    end else begin
      base_q <= ~jmp_s2;
      base_databus <= base_to_databus_en ? base_q : 7'h0;
      base_databus_oe <= base_to_databus_en;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_exists <= 1'b0;
      board_select <= 8'h00;
    end else begin
      mem_exists <= |board_decode(addr_q, base_q, cfg_size, cfg_ill);
      if (addr_reg_latch) begin
        board_select <= board_decode(addr_q, base_q, cfg_size,
                                     cfg_ill);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory cycle requests

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_latched <= 1'b0;
      slow_stage <= 1'b0;
      mem_req_pending_next <= 1'b0;
    end else begin
      if (bus_rise) begin
        mem_req_latched <= new_txn && mem_exists && legit &&
                           !(mem_req_queued && fast_mode);
      end
      if (phase_b_clk) begin
        slow_stage <= mem_req_latched;
      end
      if (phase_a_clk) begin
        mem_req_pending_next <= slow_stage;
      end
    end
  end

  assign mem_req = fast_mode ? mem_req_latched : mem_req_pending_next;

  // sequencer conditions for the three row-start sources
  assign idle_row_start = seq_idle && mem_req && !refresh_req && legit &&
                          mem_exists && fast_mode;
  assign queued_row_start = mem_req_queued && cycle0_next &&
                            !refresh_pending && fast_mode &&
                            !req_inhibit;
  assign slow_row_start = !fast_mode && cycle0_next && !req_inhibit &&
                          mem_req_pending_next && !refresh_next;

  // the set wins over the clear taken by a queued start
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req_queued <= 1'b0;
    end else if (bus_rise) begin
      if (mem_req && cycle_in_progress && fast_mode) begin
        mem_req_queued <= 1'b1;
      end else if (queued_row_start || !fast_mode) begin
        mem_req_queued <= 1'b0;
      end
    end
  end

  // hold the bus for our own data cycle, one more on a correctable error
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_busy_line_oe <= 1'b0;
      bus_busy_line_n_o <= 1'b1;
      ecc_ext <= 1'b0;
    end else if (bus_rise) begin
      if (mem_req_latched &&
          !(fast_mode && rd_wr_op && !mem_req_queued)) begin
        bus_busy_line_oe <= 1'b1;
        bus_busy_line_n_o <= 1'b0;
        ecc_ext <= 1'b0;
      end else if (bus_busy_line_oe && ecc_error && !ecc_ext) begin
        ecc_ext <= 1'b1;
      end else begin
        bus_busy_line_oe <= 1'b0;
        bus_busy_line_n_o <= 1'b1;
        ecc_ext <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // row and column strobes

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_start_reg <= 1'b0;
      refresh_row_start <= 1'b0;
      row_strobe <= 1'b0;
    end else begin
      row_start_reg <= (bus_rise && (idle_row_start || queued_row_start)) ||
                       (phase_a_clk && slow_row_start);
      refresh_row_start <= refresh_pending && seq_in_cycle01;
      row_strobe <= row_start_reg || refresh_row_start ||
                    (row_strobe && row_strobe_extend);
    end
  end

  // delay line: column timing only runs while the row strobe is held
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_cnt <= 5'h0;
      col_addr_select <= 1'b0;
      col_strobe <= 1'b0;
    end else begin
      if (!row_strobe) begin
        rs_cnt <= 5'h0;
      end else if (rs_cnt != 5'h1f) begin
        rs_cnt <= rs_cnt + 5'h1;
      end
      col_addr_select <= row_strobe &&
                         rs_cnt >= COL_SEL_CYC - 5'h1;
      col_strobe <= row_strobe && rs_cnt >= COL_STB_CYC - 5'h1 &&
                    !col_inhibit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite register slave, zero wait states

  always_comb begin
    status_word = 32'h0;
    status_word[ST_BUSY_NOW] = busy_now;
    status_word[ST_BUSY_PREV] = busy_prev;
    status_word[ST_REQ_LATCHED] = mem_req_latched;
    status_word[ST_REQ_NEXT] = mem_req_pending_next;
    status_word[ST_QUEUED] = mem_req_queued;
    status_word[ST_FAST] = fast_mode;
    status_word[ST_EXISTS] = mem_exists;
    status_word[ST_ALL_BYTES] = all_bytes;
    status_word[ST_LANES_LSB +: 4] = byte_lanes;
    status_word[ST_FUNC_LSB +: 3] = cmd_q[CMD_FUNC_MSB:0];
    status_word[ST_NOCYC] = no_cycle_code;
    status_word[ST_BOARD_LSB +: 8] = board_select;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
      hrdata <= 32'h0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
      hrdata <= 32'h0;
      if (hsel && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          ADDR_CONFIG: hrdata <= {27'h0, cfg_ill, cfg_size};
          ADDR_STATUS: hrdata <= status_word;
          ADDR_BASE: hrdata <= {25'h0, base_q};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_size <= CFG_SIZE_RST;
      cfg_ill <= CFG_ILL_RST;
    end else if (wr_pend && wr_addr == ADDR_CONFIG) begin
      cfg_size <= hwdata[CFG_SIZE_MSB:CFG_SIZE_LSB];
      cfg_ill <= hwdata[CFG_ILL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence row_go_s;
    row_start_reg ##1 row_strobe;
  endsequence

  sequence refresh_go_s;
    refresh_row_start ##1 row_strobe;
  endsequence

  exists_legal_a: assert property (
    mem_exists |-> !$past(cfg_ill) && $past(addr_q) >= $past(base_q))
    else $error("memory reported present for illegal or low address");

  base_drive_a: assert property (
    base_to_databus_en |=> base_databus_oe && base_databus == $past(base_q))
    else $error("base address not driven while enabled");

  board_onehot_a: assert property (
    $onehot0(board_select) && (board_select != 8'h00 ->
      $past(addr_reg_latch) || $stable(board_select)))
    else $error("board select not one-hot or changed without latch");

  req_qualify_a: assert property (
    $rose(mem_req_latched) |-> $past(busy_now) && !$past(busy_prev) &&
                               $past(mem_exists) && $past(legit))
    else $error("request latched without a new qualified transaction");

  slow_pipe_a: assert property (
    phase_a_clk && slow_stage |=> mem_req_pending_next)
    else $error("slow request stage not forwarded on phase_a");

  queue_set_a: assert property (
    bus_rise && mem_req && cycle_in_progress && fast_mode |=> mem_req_queued)
    else $error("queue flag not set for overlapping fast request");

  row_pulse_a: assert property (row_start_reg |-> row_go_s)
    else $error("row strobe did not follow a row start");

  col_select_a: assert property (
    $rose(col_addr_select) |-> rs_cnt == COL_SEL_CYC)
    else $error("column select at wrong delay after row strobe");

  col_strobe_a: assert property (
    $rose(col_strobe) |-> rs_cnt >= COL_STB_CYC && !$past(col_inhibit))
    else $error("column strobe early or not gated");

  refresh_row_a: assert property (
    refresh_pending && seq_in_cycle01 |=> refresh_go_s)
    else $error("refresh did not raise the row strobe");

  cmd_capture_a: assert property (
    cmd_latch_en |-> cmd_q == $past(data_s2[13:7]) &&
                     addr_q == $past(data_s2[6:0]))
    else $error("command or address not captured with latch pulse");

  busy_fastwr_a: assert property (
    bus_rise && mem_req_latched && fast_mode && rd_wr_op &&
    !mem_req_queued && !bus_busy_line_oe |=> !bus_busy_line_oe)
    else $error("busy driven during unqueued fast write");

endmodule

/* verification/mrs_bus_master.sv */
// bus master model for the shared memory bus
`timescale 1ns/1ps
module mrs_bus_master (
  // control and wire level
  input wire logic run,
  input wire logic busy_n,
  // bus pins
  output logic bclk,
  output logic drive,
  output logic [31:0] word
);
  // bus clock runs free; stopping it forces the slow oscillator
  initial begin
    bclk = 1'b0;
    drive = 1'b0;
    word = 32'h0;
    forever begin
      #32;
      bclk = run ? ~bclk : 1'b0;
    end
  end
  task send(input logic [6:0] c, input logic [6:0] a);
    int n;
    for (n = 0; n < 20 && !busy_n; n++) @(posedge bclk);
    @(posedge bclk);
    drive <= 1'b1;
    word <= {c, 1'b0, a, 17'h0};
    @(posedge bclk);
    drive <= 1'b0;
    // released word shows garbage, not the last value
    word <= ~{c, 1'b0, a, 17'h0};
    repeat (2) @(posedge bclk);
    for (n = 0; n < 20 && !busy_n; n++) @(posedge bclk);
  endtask
endmodule

/* verification/tb_top.sv */
// self-checking bench for the request and strobe front end
`timescale 1ns/1ps
module tb_top;
  import mrs_pkg::*;
  typedef struct {
    logic [6:0] cmd;
    logic [6:0] adr;
    logic ex;
    logic [7:0] brd;
    logic req;
    logic oe;
  } mrs_row_s;
  mrs_row_s rows [6] = '{
    '{7'h78, 7'h10, 1'h1, 8'h01, 1'h1, 1'h1},
    '{7'h28, 7'h11, 1'h1, 8'h02, 1'h1, 1'h1},
    '{7'h7a, 7'h10, 1'h1, 8'h01, 1'h1, 1'h0},
    '{7'h7c, 7'h10, 1'h1, 8'h01, 1'h0, 1'h0},
    '{7'h78, 7'h12, 1'h0, 8'h00, 1'h0, 1'h0},
    '{7'h78, 7'h0f, 1'h0, 8'h00, 1'h0, 1'h0}};
  logic sys_clk, rst_n, hwrite, hreadyout, run, bclk, drv, cle, req, rs, qd;
  logic bus_busy_line_oe, mem_exists, base_databus_oe, cmd_latch_en;
  logic all_bytes, rd_wr_op, no_cycle_code, mem_req_latched, mem_req_queued;
  logic fast_mode, phase_a_clk, row_strobe, col_addr_select, col_strobe;
  logic refresh_row_start, addr_reg_latch, base_to_databus_en, seq_idle;
  logic cycle0_next, seq_in_cycle01, cycle_in_progress, refresh_pending;
  logic row_strobe_extend, col_inhibit, ecc_error, busy_n_o, phase_b;
  logic [1:0] htrans, hresp;
  logic [31:0] haddr, hwdata, hrdata, word, rd;
  logic [7:0] board_select;
  logic [6:0] base_databus;
  logic [3:0] byte_lanes;
  int errors, total_checks, oe_cnt, n1, n, ts, tc, nb;
  mrs_strobe_ctrl dut (.sys_clk, .rst_n, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .bus_clock_line(bclk),
    .bus_busy_line_n_i(!(drv | bus_busy_line_oe)),
    .bus_busy_line_n_o(busy_n_o),
    .bus_busy_line_oe, .bus_data_in(word), .jumper_base_addr_n(~7'h10),
    .addr_reg_latch, .base_to_databus_en, .seq_idle, .cycle0_next,
    .seq_in_cycle01, .cycle_in_progress, .refresh_req(1'b0),
    .refresh_pending, .refresh_next(1'b0), .row_strobe_extend, .col_inhibit,
    .ecc_error, .mem_exists, .board_select, .base_databus, .base_databus_oe,
    .cmd_latch_en, .byte_lanes, .all_bytes, .rd_wr_op, .no_cycle_code,
    .busy_now(), .busy_prev(), .mem_req_latched, .mem_req_pending_next(),
    .mem_req_queued, .fast_mode, .req_inhibit(), .phase_a_clk,
    .phase_b_clk(phase_b), .row_strobe, .col_addr_select, .col_strobe,
    .refresh_row_start);
  mrs_bus_master m (.run, .busy_n(!(drv | bus_busy_line_oe)), .bclk,
    .drive(drv), .word);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task chk_bit(input string s, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %b got %b", s, e, g);
    end
  endtask
  task chk_val(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hready and read data both taken at the rising edge that ends a phase
  task rdy;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (hreadyout === 1'b1) break;
    end
    if (n >= 50) begin
      errors++;
      test_done;
    end
    rd = hrdata;
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
  endtask
  task txn(input logic [6:0] c, input logic [6:0] a);
    fork
      m.send(c, a);
    join_none
    {cle, req, rs, qd} = 4'h0;
    oe_cnt = 0;
    nb = 0;
    repeat (200) begin
      @(negedge sys_clk);
      cle |= cmd_latch_en;
      req |= mem_req_latched;
      rs |= row_strobe;
      qd |= mem_req_queued;
      oe_cnt += int'(bus_busy_line_oe);
      nb += int'(busy_n_o === 1'b0);
    end
    @(posedge sys_clk);
    addr_reg_latch <= 1'b1;
    @(posedge sys_clk);
    addr_reg_latch <= 1'b0;
    @(negedge sys_clk);
  endtask
  initial begin
    #200000;
    errors++;
    test_done;
  end
  initial begin
    {rst_n, hwrite, htrans, haddr, hwdata, addr_reg_latch} = '0;
    {base_to_databus_en, cycle0_next, seq_in_cycle01, ecc_error} = '0;
    {cycle_in_progress, refresh_pending, row_strobe_extend} = '0;
    {col_inhibit, errors, total_checks} = '0;
    {seq_idle, run} = 2'b11;
    repeat (2) @(posedge sys_clk);
    chk_val("reset state", 32'h0, 32'({row_strobe, bus_busy_line_oe,
      mem_req_latched, mem_req_queued}));
    rst_n <= 1'b1;
    ahb(1'b1, ADDR_CONFIG, 32'h2);
    ahb(1'b0, ADDR_CONFIG, 32'h0);
    chk_val("config", 32'h2, rd & 32'h1f);
    chk_val("hresp", 32'(HRESP_OKAY), 32'(hresp));
    ahb(1'b0, 8'h0c, 32'h0);
    chk_val("unmapped", 32'h0, rd);
    ahb(1'b0, ADDR_BASE, 32'h0);
    chk_val("base reg", 32'h10, rd & 32'h7f);
    base_to_databus_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_val("base bus", 32'h90, 32'({base_databus_oe, base_databus}));
    base_to_databus_en <= 1'b0;
    for (n = 0; n < 500 && fast_mode !== 1'b1; n++) @(negedge sys_clk);
    chk_bit("fast mode", 1'b1, fast_mode);
    foreach (rows[i]) begin
      txn(rows[i].cmd, rows[i].adr);
      if (i == 0) n1 = oe_cnt;
      chk_bit("cmd_latch_en", 1'b1, cle);
      chk_bit("mem_req_latched", rows[i].req, req);
      chk_bit("busy drive", rows[i].oe, oe_cnt > 0);
      chk_val("busy level", oe_cnt, nb);
      chk_bit("row_strobe", rows[i].req, rs);
      chk_bit("mem_exists", rows[i].ex, mem_exists);
      chk_val("board_select", 32'(rows[i].brd), 32'(board_select));
      chk_val("byte_lanes", 32'(rows[i].cmd[6:3]), 32'(byte_lanes));
      chk_bit("all_bytes", &rows[i].cmd[6:3], all_bytes);
      chk_bit("rd_wr_op", rows[i].cmd[1], rd_wr_op);
      chk_bit("no_cycle_code", rows[i].cmd[2], no_cycle_code);
    end
    @(posedge sys_clk);
    ecc_error <= 1'b1;
    txn(7'h78, 7'h10);
    chk_bit("busy extend", 1'b1, oe_cnt > n1 + 8);
    @(posedge sys_clk);
    {ecc_error, seq_idle, cycle_in_progress} <= 3'b001;
    txn(7'h78, 7'h10);
    chk_bit("queued", 1'b1, qd);
    chk_bit("no idle start", 1'b0, rs);
    @(posedge sys_clk);
    {cycle0_next, cycle_in_progress} <= 2'b10;
    for (n = 0; n < 20 && row_strobe !== 1'b1; n++) @(negedge sys_clk);
    chk_bit("queued start", 1'b1, row_strobe);
    @(posedge sys_clk);
    {cycle0_next, seq_idle} <= 2'b01;
    repeat (40) @(posedge sys_clk);
    row_strobe_extend <= 1'b1;
    fork
      m.send(7'h78, 7'h10);
    join_none
    for (n = 0; n < 400 && row_strobe !== 1'b1; n++) @(negedge sys_clk);
    {ts, tc} = '0;
    for (n = 0; n < 40; n++) begin
      if (col_addr_select === 1'b1 && ts == 0) ts = n;
      if (col_strobe === 1'b1 && tc == 0) tc = n;
      @(negedge sys_clk);
    end
    chk_val("col select delay", 32'(COL_SEL_CYC), ts);
    chk_val("col strobe delay", 32'(COL_STB_CYC), tc);
    chk_bit("row held", 1'b1, row_strobe);
    @(posedge sys_clk);
    row_strobe_extend <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk_bit("strobes end", 1'b0, row_strobe | col_strobe);
    repeat (200) @(posedge sys_clk);
    {refresh_pending, seq_in_cycle01, col_inhibit, row_strobe_extend} <= '1;
    {req, rs, qd} = 3'h0;
    repeat (40) begin
      @(negedge sys_clk);
      req |= refresh_row_start;
      rs |= col_addr_select;
      qd |= col_strobe;
    end
    chk_val("refresh strobes", 32'h6, 32'({req, rs, qd}));
    @(posedge sys_clk);
    {refresh_pending, seq_in_cycle01, col_inhibit, row_strobe_extend} <= '0;
    run <= 1'b0;
    for (n = 0; n < 300 && fast_mode !== 1'b0; n++) @(negedge sys_clk);
    chk_bit("slow mode", 1'b0, fast_mode);
    {ts, tc} = '0;
    repeat (64) begin
      @(negedge sys_clk);
      tc += int'(phase_a_clk);
      ts += int'(phase_b);
    end
    chk_val("phase pulses", 32'h4, tc);
    chk_val("phase_b pulses", 32'h4, ts);
    test_done;
  end
endmodule
